// ### inc/usd_pkg.sv
// constants and types of the endpoint 0 setup and host port block
package usd_pkg;
   // ****************************************
   // register map, seven-bit host addresses
   // ****************************************
   localparam logic [6:0] ADR_SETUP_BASE = 7'h00;
   localparam logic [6:0] ADR_EP0_STAT = 7'h08;
   localparam logic [6:0] ADR_IRQ_STAT1 = 7'h09;
   localparam logic [6:0] ADR_IRQ_EN1 = 7'h0a;
   localparam logic [6:0] ADR_EP0_RXCNT = 7'h0b;
   localparam logic [6:0] ADR_EP0_MAXPKT = 7'h0c;
   localparam logic [6:0] ADR_POLARITY = 7'h0d;
   localparam logic [6:0] ADR_EP0_FIFO = 7'h0e;
   localparam logic [6:0] ADR_DMA_CTL = 7'h0f;

   // ****************************************
   // field positions
   // ****************************************
   localparam int ST_RX_RDY = 0;
   localparam int ST_TX_RDY = 1;
   localparam int ST_SETUP_RDY = 2;
   localparam int IS_SETUP = 0;
   localparam int IS_RX = 6;
   localparam int IS_TX = 7;
   localparam int POL_IRQ_HI = 0;
   localparam int POL_DREQ_HI = 1;
   localparam int POL_DACK_LO = 2;
   localparam int POL_WIDE = 3;

   // ****************************************
   // reset values and sizes
   // ****************************************
   localparam logic [7:0] MAXPKT_RST = 8'h08;
   localparam logic [7:0] POL_RST = 8'h00;
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam int FIFO_DEPTH = 32;
   localparam int SETUP_LEN = 8;
   localparam int RXCNT_W = 6;

   // ****************************************
   // state encodings
   // ****************************************
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00, BUS_READ = 2'b01, BUS_WRITE = 2'b10
   } usd_bus_e;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00, RX_SETUP = 2'b01, RX_DATA = 2'b10
   } usd_rx_e;
endpackage

// ### inc/usd_fifo_if.sv
// bundle between the endpoint 0 port logic and its byte store
`timescale 1ns/1ps
interface usd_fifo_if #(parameter int W = 8, parameter int D = 32);
   logic push;
   logic [W-1:0] push_data;
   logic pop;
   logic [W-1:0] pop_data;
   logic [$clog2(D+1)-1:0] count;
   logic flush;
   // port logic side fills and drains
   modport fill (output push, push_data, pop, flush,
                 input pop_data, count);
   // storage side
   modport store (input push, push_data, pop, flush,
                  output pop_data, count);
endinterface

// ### design/usd_sync.sv
// two flip-flop synchroniser for pin inputs, one stage pair per bit
`timescale 1ns/1ps
module usd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // pins in, synchronised levels out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      // first stage feeds only the second stage
      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            meta_q <= RST[i];
            q[i] <= RST[i];
         end else begin
            meta_q <= d[i];
            q[i] <= meta_q;
         end
      end
   end
endmodule

// ### design/usd_ep0_fifo.sv
// shared transmit and receive byte store of the control endpoint
`timescale 1ns/1ps
module usd_ep0_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // fill and drain bundle
   usd_fifo_if.store f
);
   localparam int PW = $clog2(D);
   localparam int CW = $clog2(D + 1);
   logic [W-1:0] mem_q [D];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   logic do_push;
   logic do_pop;

   // full and empty refuse silently; depth must be a power of two
   assign do_push = f.push && (cnt_q != CW'(D));
   assign do_pop = f.pop && (cnt_q != '0);
   assign f.count = cnt_q;
   assign f.pop_data = mem_q[rd_q];

   // pointers and fill level, flush wins over everything
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (f.flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) wr_q <= wr_q + 1'b1;
         if (do_pop) rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
      end
   end

   // storage entries, each cleared at reset
   for (genvar i = 0; i < D; i++) begin : g_ent
      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            mem_q[i] <= '0;
         end else if (do_push && !f.flush && wr_q == PW'(i)) begin
            mem_q[i] <= f.push_data;
         end
      end
   end

   AST_FIFO_FULL_HOLD: assert property (@(posedge clk_sys) disable iff (reset) // R10
      f.push && !f.pop && !f.flush && cnt_q == CW'(D) |=> cnt_q == CW'(D))
      else $error("fifo grew past its depth");
   AST_FIFO_PUSH_ONE: assert property (@(posedge clk_sys) disable iff (reset) // R10
      f.push && !f.pop && !f.flush && cnt_q < CW'(D)
      |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("fifo push did not add one byte");
endmodule

// ### design/usd_ep0_port.sv
// host bus port and endpoint 0 setup stage logic of the usb device
`timescale 1ns/1ps
// What this block does
// R1 - ignore usb-reset registers while lines indeterminate
// R2 - interrupt and dma requests active-low, selectable
// R3 - dma acknowledges active-high, selectable polarity
// R4 - latch pin: address strobe or pull-up control
// R5 - host drives active-low chip select, strobes
// R6 - sixteen-bit setup-pair reads: muxed low, separate high
// R7 - format select picks separate or muxed address
// R8 - two dma requests, each answered by acknowledge
// R9 - reset initialises all logic
// R10 - endpoint 0 only, shared 32-byte fifo
// R11 - control read, write and no-data forms
// R12 - eight setup bytes in eight read registers
// R13 - setup arrival sets status and interrupt bits
// R14 - setup interrupt only when its enable set
// R15 - setup flagged only after error-free packet
// R16 - packet ready flags, receive count, max packet
// R17 - irq when any enabled status bit set
// R18 - setup registers read-only, replaced per packet
module usd_ep0_port #(
   parameter int FIFO_DEPTH = usd_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // host bus strobes and address pins
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [6:0] host_addr_bus,
   input wire logic latch_or_pullup_ctl,
   input wire logic addr_format_select,
   // host data lanes, split into in, out and enable
   input wire logic [7:0] host_muxed_low_byte_i,
   output logic [7:0] host_muxed_low_byte_o,
   output logic host_muxed_low_byte_oe,
   input wire logic [7:0] host_high_byte_i,
   output logic [7:0] host_high_byte_o,
   output logic host_high_byte_oe,
   // pull-up, interrupt and dma pins
   output logic pullup_en,
   output logic irq_out,
   output logic [1:0] dma_req_out,
   input wire logic [1:0] dma_ack_in,
   // serial engine side, same clock
   input wire logic usb_line_indeterminate,
   input wire logic usb_bus_reset,
   input wire logic usb_rx_setup,
   input wire logic usb_rx_out,
   input wire logic usb_rx_valid,
   input wire logic [7:0] usb_rx_data,
   input wire logic usb_rx_end_ok,
   input wire logic usb_rx_end_err,
   input wire logic usb_tx_pop,
   output logic [7:0] usb_tx_data,
   output logic usb_tx_avail,
   input wire logic usb_tx_done
);
   localparam int SW = 30;
   localparam logic [SW-1:0] PIN_RST = {3'b111, 27'h0000000};
   localparam int CW = $clog2(FIFO_DEPTH + 1);

   // ****************************************
   // pin synchronisation
   // ****************************************
   logic [SW-1:0] pin_s;
   logic cs_s;
   logic rd_s;
   logic wr_s;
   logic ale_s;
   logic mux_s;
   logic [1:0] ack_s;
   logic [6:0] adr_s;
   logic [7:0] lo_s;
   logic [7:0] hi_s;

   usd_sync #(.W(SW), .RST(PIN_RST)) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .d({cs_n, rd_n, wr_n, latch_or_pullup_ctl, addr_format_select,
          dma_ack_in, host_addr_bus, host_muxed_low_byte_i,
          host_high_byte_i}),
      .q(pin_s)
   );
   assign {cs_s, rd_s, wr_s, ale_s, mux_s, ack_s, adr_s, lo_s, hi_s} = pin_s;

   // ****************************************
   // byte store
   // ****************************************
   usd_fifo_if #(.W(8), .D(FIFO_DEPTH)) fif ();
   usd_ep0_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .f(fif.store)
   );

   // ****************************************
   // state
   // ****************************************
   usd_pkg::usd_bus_e bus_q;
   usd_pkg::usd_rx_e rx_q;
   logic [6:0] alat_q;
   logic [6:0] addr;
   logic rd_act;
   logic wr_act;
   logic wr_fire;
   logic rd_done;
   logic blk;
   logic [63:0] setup_q;
   logic [63:0] shadow_q;
   logic [3:0] scnt_q;
   logic setup_commit;
   logic rx_commit;
   logic st_rx_q;
   logic st_tx_q;
   logic st_setup_q;
   logic [7:0] irq_stat_q;
   logic [7:0] irq_en_q;
   logic [7:0] maxpkt_q;
   logic [7:0] pol_q;
   logic [usd_pkg::RXCNT_W-1:0] rxcnt_q;
   logic [1:0] dreq_pend_q;
   logic [1:0] ack_on;
   logic [7:0] wdat;
   logic [7:0] status;

   // strobes are active low; chip select qualifies both
   assign rd_act = !cs_s && !rd_s; // R5
   assign wr_act = !cs_s && !wr_s; // R5
   assign wr_fire = (bus_q == usd_pkg::BUS_IDLE) && wr_act && !rd_act;
   assign rd_done = (bus_q == usd_pkg::BUS_READ) && !rd_act;
   assign addr = mux_s ? alat_q : adr_s; // R7
   assign wdat = lo_s;
   // writes to usb-reset registers are lost while lines float
   assign blk = usb_line_indeterminate; // R1
   assign status = {5'h00, st_setup_q, st_tx_q, st_rx_q}; // R16

   // multiplexed mode latches the address while the strobe is high
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         alat_q <= '0;
      end else if (mux_s && ale_s) begin
         alat_q <= lo_s[6:0]; // R4
      end
   end

   // ****************************************
   // host bus sequencer
   // ****************************************
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bus_q <= usd_pkg::BUS_IDLE; // R9
      end else begin
         case (bus_q)
            usd_pkg::BUS_IDLE: begin
               if (rd_act) bus_q <= usd_pkg::BUS_READ;
               else if (wr_act) bus_q <= usd_pkg::BUS_WRITE;
            end
            usd_pkg::BUS_READ: begin
               if (!rd_act) bus_q <= usd_pkg::BUS_IDLE;
            end
            usd_pkg::BUS_WRITE: begin
               if (!wr_act) bus_q <= usd_pkg::BUS_IDLE;
            end
            default: bus_q <= usd_pkg::BUS_IDLE;
         endcase
      end
   end

   // register read multiplexer, unmapped reads return zero
   function automatic logic [7:0] rd_mux(input logic [6:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (a[6:3] == usd_pkg::ADR_SETUP_BASE[6:3]) begin
         r = setup_q[a[2:0]*8 +: 8]; // R12
      end else begin
         case (a)
            usd_pkg::ADR_EP0_STAT: r = status;
            usd_pkg::ADR_IRQ_STAT1: r = irq_stat_q;
            usd_pkg::ADR_IRQ_EN1: r = irq_en_q;
            usd_pkg::ADR_EP0_RXCNT: r = {2'b00, rxcnt_q};
            usd_pkg::ADR_EP0_MAXPKT: r = maxpkt_q;
            usd_pkg::ADR_POLARITY: r = pol_q;
            usd_pkg::ADR_EP0_FIFO: r = fif.pop_data;
            usd_pkg::ADR_DMA_CTL: r = {6'h00, dreq_pend_q};
            default: r = 8'h00;
         endcase
      end
      return r;
   endfunction

   // read lanes; wide mode pairs an even setup byte with the next
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         host_muxed_low_byte_o <= 8'h00;
         host_muxed_low_byte_oe <= 1'b0;
         host_high_byte_o <= 8'h00;
         host_high_byte_oe <= 1'b0;
      end else begin
         host_muxed_low_byte_o <= rd_mux(addr);
         host_muxed_low_byte_oe <= rd_act && (bus_q == usd_pkg::BUS_READ);
         host_high_byte_o <= (addr[6:3] == 4'h0 && !addr[0]) ?
                             rd_mux(addr | 7'h01) : 8'h00; // R6
         host_high_byte_oe <= rd_act && (bus_q == usd_pkg::BUS_READ) &&
                              pol_q[usd_pkg::POL_WIDE]; // R6
      end
   end

   // ****************************************
   // setup and data stage reception
   // ****************************************
   assign setup_commit = (rx_q == usd_pkg::RX_SETUP) && usb_rx_end_ok &&
                         (scnt_q == 4'(usd_pkg::SETUP_LEN)); // R15
   assign rx_commit = (rx_q == usd_pkg::RX_DATA) && usb_rx_end_ok;

   // a setup token always wins; data is refused while the last is unread
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rx_q <= usd_pkg::RX_IDLE;
         scnt_q <= '0;
      end else if (usb_rx_setup) begin
         rx_q <= usd_pkg::RX_SETUP; // R11
         scnt_q <= '0;
      end else if (usb_rx_out && rx_q == usd_pkg::RX_IDLE && !st_rx_q) begin
         rx_q <= usd_pkg::RX_DATA; // R11
      end else if (usb_rx_end_ok || usb_rx_end_err) begin
         rx_q <= usd_pkg::RX_IDLE;
      end else if (rx_q == usd_pkg::RX_SETUP && usb_rx_valid &&
                   scnt_q != 4'(usd_pkg::SETUP_LEN)) begin
         scnt_q <= scnt_q + 4'h1;
      end
   end

   // shadow bytes keep visible setup registers intact until a good end
   for (genvar i = 0; i < usd_pkg::SETUP_LEN; i++) begin : g_setup
      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            shadow_q[i*8 +: 8] <= 8'h00;
            setup_q[i*8 +: 8] <= 8'h00;
         end else begin
            if (rx_q == usd_pkg::RX_SETUP && usb_rx_valid &&
                scnt_q == 4'(i)) begin
               shadow_q[i*8 +: 8] <= usb_rx_data;
            end
            if (setup_commit) setup_q[i*8 +: 8] <= shadow_q[i*8 +: 8]; // R18
         end
      end
   end

   // fifo traffic: host writes and usb data in, host reads and usb out
   assign fif.flush = usb_bus_reset || usb_rx_setup ||
                      ((rx_q == usd_pkg::RX_DATA) && usb_rx_end_err); // R10
   assign fif.push = (wr_fire && addr == usd_pkg::ADR_EP0_FIFO && !blk) ||
                     ((rx_q == usd_pkg::RX_DATA) && usb_rx_valid &&
                      {{(8-CW){1'b0}}, fif.count} < maxpkt_q); // R16
   assign fif.push_data = (rx_q == usd_pkg::RX_DATA) ? usb_rx_data : wdat;
   assign fif.pop = (rd_done && addr == usd_pkg::ADR_EP0_FIFO) ||
                    usb_tx_pop; // R11

   // ****************************************
   // status, enables and polarity
   // ****************************************
   // endpoint flags; hardware set wins over a same-cycle host clear
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st_rx_q <= 1'b0;
         st_tx_q <= 1'b0;
         st_setup_q <= 1'b0;
      end else if (usb_bus_reset) begin
         st_rx_q <= 1'b0;
         st_tx_q <= 1'b0;
         st_setup_q <= 1'b0;
      end else begin
         if (setup_commit) st_setup_q <= 1'b1; // R13
         else if (wr_fire && !blk && addr == usd_pkg::ADR_EP0_STAT &&
                  wdat[usd_pkg::ST_SETUP_RDY]) st_setup_q <= 1'b0; // R1
         if (rx_commit) st_rx_q <= 1'b1; // R16
         else if (wr_fire && !blk && addr == usd_pkg::ADR_EP0_STAT &&
                  wdat[usd_pkg::ST_RX_RDY]) st_rx_q <= 1'b0;
         if (wr_fire && !blk && addr == usd_pkg::ADR_EP0_STAT &&
             wdat[usd_pkg::ST_TX_RDY]) st_tx_q <= 1'b1; // R16
         else if (usb_tx_done || usb_rx_setup) st_tx_q <= 1'b0;
      end
   end

   // interrupt causes, write one to clear, events win
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irq_stat_q <= 8'h00;
      end else begin
         for (int b = 0; b < 8; b++) begin
            if ((b == usd_pkg::IS_SETUP && setup_commit) || // R13
                (b == usd_pkg::IS_RX && rx_commit) ||
                (b == usd_pkg::IS_TX && usb_tx_done)) begin
               irq_stat_q[b] <= 1'b1;
            end else if (wr_fire && addr == usd_pkg::ADR_IRQ_STAT1 &&
                         wdat[b]) begin
               irq_stat_q[b] <= 1'b0;
            end
         end
      end
   end

   // usb-reset registers, write-protected while lines float
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irq_en_q <= usd_pkg::IRQ_EN_RST;
         maxpkt_q <= usd_pkg::MAXPKT_RST;
      end else if (usb_bus_reset) begin
         irq_en_q <= usd_pkg::IRQ_EN_RST;
         maxpkt_q <= usd_pkg::MAXPKT_RST;
      end else if (wr_fire && !blk) begin // R1
         if (addr == usd_pkg::ADR_IRQ_EN1) irq_en_q <= wdat;
         if (addr == usd_pkg::ADR_EP0_MAXPKT) maxpkt_q <= wdat; // R16
      end
   end

   // receive count captured with the packet-ready flag
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxcnt_q <= '0;
      end else if (rx_commit) begin
         rxcnt_q <= usd_pkg::RXCNT_W'(fif.count); // R16
      end
   end

   // polarity survives usb resets; only the device reset clears it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pol_q <= usd_pkg::POL_RST; // R2
      end else if (wr_fire && addr == usd_pkg::ADR_POLARITY) begin
         pol_q <= wdat; // R3
      end
   end

   // ****************************************
   // dma request and acknowledge
   // ****************************************
   assign ack_on = ack_s ^ {2{pol_q[usd_pkg::POL_DACK_LO]}}; // R3

   // software raises a request; the matching acknowledge retires it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dreq_pend_q <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (wr_fire && addr == usd_pkg::ADR_DMA_CTL && wdat[c]) begin
               dreq_pend_q[c] <= 1'b1;
            end else if (ack_on[c]) begin
               dreq_pend_q[c] <= 1'b0; // R8
            end
         end
      end
   end

   // ****************************************
   // output pins
   // ****************************************
   // idle level of each request is the opposite of its active level
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irq_out <= 1'b1;
         dma_req_out <= 2'b11;
         pullup_en <= 1'b0;
      end else begin
         irq_out <= (|(irq_stat_q & irq_en_q)) ? // R17
                    pol_q[usd_pkg::POL_IRQ_HI] : // R14
                    !pol_q[usd_pkg::POL_IRQ_HI]; // R2
         dma_req_out <= ~(dreq_pend_q ^
                          {2{pol_q[usd_pkg::POL_DREQ_HI]}}); // R8
         pullup_en <= !mux_s && ale_s; // R4
      end
   end

   // usb transmit view lags a pop by one cycle, so avail drops then
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         usb_tx_data <= 8'h00;
         usb_tx_avail <= 1'b0;
      end else begin
         usb_tx_data <= fif.pop_data;
         usb_tx_avail <= st_tx_q && (fif.count != '0) && !usb_tx_pop;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   AST_SETUP_FLAGS: assert property (@(posedge clk_sys) disable iff (reset) // R13
      setup_commit && !usb_bus_reset |=> st_setup_q && irq_stat_q[0])
      else $error("setup arrival did not raise both flags");
   AST_SETUP_IRQ: assert property (@(posedge clk_sys) disable iff (reset) // R14
      irq_stat_q == 8'h01 && !irq_en_q[0] && $stable(pol_q)
      |=> irq_out == !$past(pol_q[0]))
      else $error("setup interrupt escaped its enable");
   AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (reset) // R17
      |(irq_stat_q & irq_en_q) ##1 $stable(pol_q) |-> irq_out == pol_q[0])
      else $error("enabled cause did not drive interrupt");
   AST_FLOAT_BLOCK: assert property (@(posedge clk_sys) disable iff (reset) // R1
      wr_fire && blk && !usb_bus_reset |=> $stable(irq_en_q) &&
      $stable(maxpkt_q))
      else $error("write landed while lines were indeterminate");
   AST_SETUP_HOLD: assert property (@(posedge clk_sys) disable iff (reset) // R18
      !setup_commit |=> setup_q == $past(setup_q))
      else $error("setup bytes changed without a new packet");
   AST_SETUP_CLEAN: assert property (@(posedge clk_sys) disable iff (reset) // R15
      usb_rx_end_err || scnt_q != 4'h8 |-> !setup_commit)
      else $error("setup accepted from a bad packet");
   AST_RX_COUNT: assert property (@(posedge clk_sys) disable iff (reset) // R16
      rx_commit |=> rxcnt_q == $past(fif.count) ##1 st_rx_q)
      else $error("receive count or ready flag wrong");
   AST_DACK_RETIRE: assert property (@(posedge clk_sys) disable iff (reset) // R8
      ack_on[0] && !(wr_fire && addr == usd_pkg::ADR_DMA_CTL)
      |=> !dreq_pend_q[0] ##1 dma_req_out[0] == !pol_q[1])
      else $error("acknowledge did not retire the request");
endmodule

// ### bench/usd_host_model.sv
// host processor bus model driving the register port pins
`timescale 1ns/1ps
module usd_host_model (
   // clock
   input wire logic clk_sys,
   // strobes, address and low lane
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [6:0] addr,
   output logic [7:0] dat,
   // device answer
   input wire logic [7:0] rdat,
   input wire logic oe
);
   // strobes idle high until the first access
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 7'h00;
      dat = 8'h00;
   end

   // one access; strobes held long enough for the pin synchronisers
   task automatic acc(input logic w, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      addr = a;
      dat = d;
      cs_n = 1'b0;
      wr_n = !w;
      rd_n = w;
      repeat (4) @(posedge clk_sys);
      #1;
      while (!w && oe !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      // answer taken once settled, then the strobes let go
      q = rdat;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      dat = ~dat;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
endmodule

// ### bench/usd_ep0_port_bench.sv
// self-checking bench of the endpoint 0 setup and host port
`timescale 1ns/1ps
module usd_ep0_port_bench;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic ind = 1'b0;
   logic su = 1'b0;
   logic vl = 1'b0;
   logic ok = 1'b0;
   logic er = 1'b0;
   logic latch = 1'b0;
   logic mx = 1'b0;
   logic ob = 1'b0;
   logic [1:0] ack = 2'b00;
   logic [7:0] rxd = 8'h00;
   logic cs_n, rd_n, wr_n, oe, pu, irq;
   logic [6:0] addr;
   logic [7:0] hd, lo_o, q, hi;
   logic [1:0] dreq;
   logic [6:0] ra [6];
   logic [7:0] re [6];
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;

   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;

   usd_host_model hm (.clk_sys(clk_sys), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .addr(addr), .dat(hd), .rdat(lo_o), .oe(oe));

   // low lane wire resolved from both drivers
   usd_ep0_port dut_u (.clk_sys(clk_sys), .reset(reset), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .host_addr_bus(addr),
      .latch_or_pullup_ctl(latch), .addr_format_select(mx),
      .host_muxed_low_byte_i(oe ? lo_o : hd),
      .host_muxed_low_byte_o(lo_o), .host_muxed_low_byte_oe(oe),
      .host_high_byte_i(8'h00), .host_high_byte_o(hi),
      .host_high_byte_oe(), .pullup_en(pu), .irq_out(irq),
      .dma_req_out(dreq), .dma_ack_in(ack),
      .usb_line_indeterminate(ind), .usb_bus_reset(1'b0),
      .usb_rx_setup(su), .usb_rx_out(ob), .usb_rx_valid(vl),
      .usb_rx_data(rxd), .usb_rx_end_ok(ok), .usb_rx_end_err(er),
      .usb_tx_pop(1'b0), .usb_tx_data(), .usb_tx_avail(),
      .usb_tx_done(1'b0));

   // ****************************************
   // helpers
   // ****************************************
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      hm.acc(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      hm.acc(1'b1, a, d, q);
   endtask
   // setup or out packet of bytes 30..37, ended good or bad
   task automatic pkt(input logic bad, input logic o);
      su = !o;
      ob = o;
      for (int i = 0; i < 8; i++) begin
         wt(1);
         su = 1'b0;
         ob = 1'b0;
         vl = 1'b1;
         rxd = 8'h30 + 8'(i);
      end
      wt(1);
      vl = 1'b0;
      ok = !bad;
      er = bad;
      wt(1);
      ok = 1'b0;
      er = 1'b0;
      wt(3);
   endtask
   task automatic complete_run;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // hang guard, far above the few hundred cycles expected
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         complete_run();
      end
   end

   // reset values as table rows, unmapped address last
   initial begin
      ra = '{usd_pkg::ADR_EP0_MAXPKT, usd_pkg::ADR_POLARITY,
         usd_pkg::ADR_IRQ_EN1, 7'h08, 7'h09, 7'h7f};
      re = '{usd_pkg::MAXPKT_RST, usd_pkg::POL_RST,
         usd_pkg::IRQ_EN_RST, 8'h00, 8'h00, 8'h00};
      wt(4);
      reset = 1'b0;
      for (int i = 0; i < 6; i++) begin
         rdc(ra[i], re[i]);
      end
      chk({6'h00, dreq}, 8'h03);
      chk({7'h00, irq}, 8'h01);
      latch = 1'b1;
      wt(4);
      chk({7'h00, pu}, 8'h01);
      ind = 1'b1;
      wr(usd_pkg::ADR_IRQ_EN1, 8'h01);
      ind = 1'b0;
      rdc(usd_pkg::ADR_IRQ_EN1, 8'h00);
      pkt(1'b1, 1'b0);
      rdc(usd_pkg::ADR_EP0_STAT, 8'h00);
      pkt(1'b0, 1'b0);
      rdc(usd_pkg::ADR_EP0_STAT, 8'h04);
      rdc(usd_pkg::ADR_IRQ_STAT1, 8'h01);
      chk({7'h00, irq}, 8'h01);
      wr(usd_pkg::ADR_IRQ_EN1, 8'h01);
      wt(2);
      chk({7'h00, irq}, 8'h00);
      wr(usd_pkg::ADR_POLARITY, 8'h01);
      wt(2);
      chk({7'h00, irq}, 8'h01);
      wr(usd_pkg::ADR_IRQ_STAT1, 8'h01);
      wt(2);
      chk({7'h00, irq}, 8'h00);
      wr(usd_pkg::ADR_SETUP_BASE, 8'hff);
      for (int i = 0; i < 8; i++) begin
         rdc(7'(i), 8'h30 + 8'(i));
      end
      // wide reads pair an even setup byte with the next one
      wr(usd_pkg::ADR_POLARITY, 8'h09);
      rdc(7'h02, 8'h32);
      chk(hi, 8'h33);
      // out data stage: eight bytes fill up to the packet size
      pkt(1'b0, 1'b1);
      rdc(usd_pkg::ADR_EP0_RXCNT, 8'h08);
      rdc(usd_pkg::ADR_EP0_STAT, 8'h05);
      rdc(usd_pkg::ADR_EP0_FIFO, 8'h30);
      // muxed address: latch 0c, pins left at 00
      mx = 1'b1;
      hm.dat = 8'h0c;
      wt(4);
      chk({7'h00, pu}, 8'h00);
      latch = 1'b0;
      wt(2);
      rdc(7'h00, usd_pkg::MAXPKT_RST);
      mx = 1'b0;
      wr(usd_pkg::ADR_DMA_CTL, 8'h01);
      wt(2);
      chk({6'h00, dreq}, 8'h02);
      ack = 2'b01;
      wt(8);
      chk({6'h00, dreq}, 8'h03);
      complete_run();
   end
endmodule
